// File: hw/gdmh_pkg.sv
// Constants and types for the GPIB device message handler
package gdmh_pkg;

    localparam int DATA_W = 7;
    localparam int FIFO_W = 11;
    localparam int FIFO_DEPTH = 16;

    // Input buffer word layout: {query, common, msg_end, cmd_end, char[6:0]}
    localparam int FW_CMD_END = 7;
    localparam int FW_MSG_END = 8;
    localparam int FW_COMMON = 9;
    localparam int FW_QUERY = 10;

    // Interface message codes on the data lines while ATN is true
    localparam logic [6:0] IM_GTL = 7'h01;
    localparam logic [6:0] IM_SDC = 7'h04;
    localparam logic [6:0] IM_GET = 7'h08;
    localparam logic [6:0] IM_LLO = 7'h11;
    localparam logic [6:0] IM_DCL = 7'h14;
    localparam logic [6:0] IM_SPE = 7'h18;
    localparam logic [6:0] IM_SPD = 7'h19;
    localparam logic [6:0] IM_UNL = 7'h3F;
    localparam logic [6:0] IM_UNT = 7'h5F;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK = 2'h2;

    // Characters of command text
    localparam logic [6:0] CH_LF = 7'h0A;
    localparam logic [6:0] CH_CR = 7'h0D;
    localparam logic [6:0] CH_SPACE = 7'h20;
    localparam logic [6:0] CH_STAR = 7'h2A;
    localparam logic [6:0] CH_SEMI = 7'h3B;
    localparam logic [6:0] CH_QMARK = 7'h3F;
    localparam logic [6:0] RESP_TERM = CH_LF;

    // Status byte bit that carries the service request
    localparam int STB_RQS = 6;

    typedef enum logic [1:0] {AH_READY, AH_TAKE, AH_HOLD} gdmh_ah_t;
    typedef enum logic [1:0] {SH_IDLE, SH_WAIT_RFD, SH_VALID} gdmh_sh_t;
    typedef enum logic [1:0] {RL_LOCS, RL_REMS, RL_LWLS, RL_RWLS} gdmh_rl_t;

endpackage

// File: hw/gdmh_fifo.sv
// Synchronous FIFO with registered read data and flush
`timescale 1ns/1ps
module gdmh_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // DEPTH must be a power of two so the pointers wrap by themselves
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic load;

    assign in_ready = cnt_r != (AW+1)'(DEPTH);
    assign push = in_valid & in_ready;
    assign load = (cnt_r != '0) & (!out_valid | out_ready);

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else if (flush) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_r <= wr_r + AW'(push);
            rd_r <= rd_r + AW'(load);
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    // Output stage register holds one word beyond the memory
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (flush) begin
            out_valid <= 1'b0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_data <= mem_r[rd_r];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

endmodule

// File: hw/gdmh_top.sv
// GPIB device message handler: addressing, handshake, clears and command sorting
// Functional notes
// - ATN true bytes are interface messages
// - Every byte moves by three-wire handshake
// - Hold NRFD until ready, NDAC until accepted
// - Device clear empties input and output buffers
// - Selected clear acts only while listener addressed
// - Trigger starts measurement, reading goes to output
// - EOI with byte marks last byte
// - Remote/local follows GTL, LLO and REN
// - IFC drops all addressing to quiescent state
// - Own listen address makes device listener
// - Own talk address makes device talker
// - Unlisten leaves listener addressed state
// - Untalk leaves talker addressed state
// - After poll enable, next talk sends status
// - Poll disable resumes normal output data
// - Serial poll response is the status byte
// - Assert SRQ when attention is needed
// - EOI accompanies final terminator of responses
// - Leading asterisk marks a common command
// - Trailing question mark marks a query
// - Semicolons split commands, kept in order
// - CR or EOI byte ends program message
// - Top data bit ignored, seven-bit ASCII
`timescale 1ns/1ps
module gdmh_top
    import gdmh_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [4:0] my_addr,
    input wire logic [7:0] dio_i,
    output logic [7:0] dio_o,
    output logic dio_oe,
    input wire logic dav_i,
    output logic dav_o,
    output logic dav_oe,
    input wire logic nrfd_i,
    output logic nrfd_o,
    output logic nrfd_oe,
    input wire logic ndac_i,
    output logic ndac_o,
    output logic ndac_oe,
    input wire logic eoi_i,
    output logic eoi_o,
    output logic eoi_oe,
    output logic srq_o,
    output logic srq_oe,
    input wire logic atn_i,
    input wire logic ifc_i,
    input wire logic ren_i,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic [DATA_W-1:0] cmd_data,
    output logic cmd_end,
    output logic cmd_msg_end,
    output logic cmd_common,
    output logic cmd_query,
    input wire logic resp_valid,
    output logic resp_ready,
    input wire logic [DATA_W-1:0] resp_data,
    input wire logic resp_last,
    input wire logic [7:0] status_in,
    input wire logic srq_req,
    output logic trig_o,
    output logic dev_clear_o,
    output logic remote_o,
    output logic lockout_o,
    output logic listen_o,
    output logic talk_o,
    output logic spoll_o
);

    function automatic logic addr_hit(input logic [6:0] code, input logic [1:0] grp,
                                      input logic [4:0] addr);
        addr_hit = (code[6:5] == grp) && (code[4:0] == addr);
    endfunction

    // Bus pins are asynchronous; data settles before DAV so skew is harmless
    logic [14:0] meta_r;
    logic [14:0] sync_r;
    logic [7:0] dio_s;
    logic dav_s;
    logic nrfd_s;
    logic ndac_s;
    logic eoi_s;
    logic atn_s;
    logic ifc_s;
    logic ren_s;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= {dio_i, dav_i, nrfd_i, ndac_i, eoi_i, atn_i, ifc_i, ren_i};
            sync_r <= meta_r;
        end
    end

    assign {dio_s, dav_s, nrfd_s, ndac_s, eoi_s, atn_s, ifc_s, ren_s} = sync_r;

    // Acceptor handshake
    gdmh_ah_t ah_r;
    logic [6:0] rx_r;
    logic rx_eoi_r;
    logic rx_atn_r;
    logic lstn_r;
    logic tlk_r;
    logic spe_r;
    logic fifo_in_ready;
    logic ah_active;
    logic ready_now;
    logic take;
    logic im_take;
    logic dt_take;
    logic talk_act;

    assign talk_act = tlk_r & !atn_s;
    assign ah_active = !talk_act;
    assign ready_now = atn_s | !lstn_r | fifo_in_ready;
    assign take = ah_r == AH_TAKE;
    assign im_take = take & rx_atn_r;
    assign dt_take = take & !rx_atn_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ah_r <= AH_READY;
            rx_r <= '0;
            rx_eoi_r <= 1'b0;
            rx_atn_r <= 1'b0;
        end else if (!ah_active || ifc_s) begin
            ah_r <= AH_READY;
        end else begin
            case (ah_r)
                AH_READY: begin
                    if (ready_now && dav_s) begin
                        rx_r <= dio_s[6:0];
                        rx_eoi_r <= eoi_s;
                        rx_atn_r <= atn_s;
                        ah_r <= AH_TAKE;
                    end
                end
                AH_TAKE: ah_r <= AH_HOLD;
                AH_HOLD: begin
                    if (!dav_s) begin
                        ah_r <= AH_READY;
                    end
                end
                default: ah_r <= AH_READY;
            endcase
        end
    end

    // Open-drain lines: value is the asserted level, the enable pulls the line
    assign nrfd_o = 1'b1;
    assign ndac_o = 1'b1;
    assign nrfd_oe = ah_active && (ah_r != AH_READY || !ready_now);
    assign ndac_oe = ah_active && ah_r != AH_HOLD;

    // Interface message decode
    logic clr;
    logic mla_hit;
    logic gtl_hit;
    logic llo_hit;

    assign mla_hit = im_take && addr_hit(rx_r, GRP_LISTEN, my_addr);
    assign gtl_hit = im_take && rx_r == IM_GTL && lstn_r;
    assign llo_hit = im_take && rx_r == IM_LLO;
    assign clr = im_take && (rx_r == IM_DCL || (rx_r == IM_SDC && lstn_r));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lstn_r <= 1'b0;
        end else if (ifc_s) begin
            lstn_r <= 1'b0;
        end else if (mla_hit) begin
            lstn_r <= 1'b1;
        end else if (im_take && rx_r == IM_UNL) begin
            lstn_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tlk_r <= 1'b0;
        end else if (ifc_s) begin
            tlk_r <= 1'b0;
        end else if (im_take && addr_hit(rx_r, GRP_TALK, my_addr)) begin
            tlk_r <= 1'b1;
        end else if (im_take && rx_r[6:5] == GRP_TALK) begin
            tlk_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            spe_r <= 1'b0;
        end else if (ifc_s) begin
            spe_r <= 1'b0;
        end else if (im_take && rx_r == IM_SPE) begin
            spe_r <= 1'b1;
        end else if (im_take && rx_r == IM_SPD) begin
            spe_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trig_o <= 1'b0;
            dev_clear_o <= 1'b0;
        end else begin
            trig_o <= im_take && rx_r == IM_GET && lstn_r;
            dev_clear_o <= clr;
        end
    end

    // Remote/local state
    gdmh_rl_t rl_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rl_r <= RL_LOCS;
        end else if (!ren_s) begin
            rl_r <= RL_LOCS;
        end else begin
            case (rl_r)
                RL_LOCS: begin
                    if (mla_hit) begin
                        rl_r <= RL_REMS;
                    end else if (llo_hit) begin
                        rl_r <= RL_LWLS;
                    end
                end
                RL_REMS: begin
                    if (gtl_hit) begin
                        rl_r <= RL_LOCS;
                    end else if (llo_hit) begin
                        rl_r <= RL_RWLS;
                    end
                end
                RL_LWLS: begin
                    if (mla_hit) begin
                        rl_r <= RL_RWLS;
                    end
                end
                RL_RWLS: begin
                    if (gtl_hit) begin
                        rl_r <= RL_LWLS;
                    end
                end
                default: rl_r <= RL_LOCS;
            endcase
        end
    end

    assign remote_o = rl_r == RL_REMS || rl_r == RL_RWLS;
    assign lockout_o = rl_r == RL_LWLS || rl_r == RL_RWLS;
    assign listen_o = lstn_r;
    assign talk_o = tlk_r;
    assign spoll_o = spe_r;

    // Command text sorting into the input buffer
    logic first_r;
    logic common_r;
    logic qry_r;
    logic keep;
    logic push;
    logic is_end;
    logic msg_end;
    logic is_common;
    logic [FIFO_W-1:0] fifo_in;
    logic [FIFO_W-1:0] fifo_out;

    // Control characters other than CR and LF carry no text, but an EOI byte must still end the message
    assign keep = rx_r >= CH_SPACE || rx_r == CH_CR || rx_r == CH_LF || rx_eoi_r;
    assign push = dt_take && lstn_r && keep;
    assign msg_end = rx_eoi_r || rx_r == CH_CR;
    assign is_end = msg_end || rx_r == CH_SEMI;
    assign is_common = first_r ? rx_r == CH_STAR : common_r;
    assign fifo_in = {is_end && (rx_r == CH_QMARK || qry_r), is_common, msg_end, is_end, rx_r};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            first_r <= 1'b1;
            common_r <= 1'b0;
            qry_r <= 1'b0;
        end else if (clr) begin
            first_r <= 1'b1;
            common_r <= 1'b0;
            qry_r <= 1'b0;
        end else if (push) begin
            if (is_end) begin
                first_r <= 1'b1;
                common_r <= 1'b0;
                qry_r <= 1'b0;
            end else if (rx_r != CH_SPACE) begin
                first_r <= 1'b0;
                common_r <= is_common;
                qry_r <= rx_r == CH_QMARK;
            end
        end
    end

    // Back-pressure: a full buffer keeps NRFD asserted toward the controller
    gdmh_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_in_buf (
        .clk(clk),
        .rst_b(rst_b),
        .flush(clr),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(cmd_valid),
        .out_ready(cmd_ready),
        .out_data(fifo_out)
    );

    assign cmd_data = fifo_out[DATA_W-1:0];
    assign cmd_end = fifo_out[FW_CMD_END];
    assign cmd_msg_end = fifo_out[FW_MSG_END];
    assign cmd_common = fifo_out[FW_COMMON];
    assign cmd_query = fifo_out[FW_QUERY];

    // Source handshake and output holding register
    gdmh_sh_t sh_r;
    logic [7:0] tx_r;
    logic tx_eoi_r;
    logic dav_r;
    logic ob_v_r;
    logic [6:0] ob_d_r;
    logic ob_last_r;
    logic term_pend_r;
    logic sp_done_r;
    logic srq_r;
    logic [7:0] stb_byte;

    always_comb begin
        stb_byte = status_in;
        stb_byte[STB_RQS] = srq_r;
    end

    assign resp_ready = !ob_v_r && !clr;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_r <= SH_IDLE;
            tx_r <= '0;
            tx_eoi_r <= 1'b0;
            dav_r <= 1'b0;
            ob_v_r <= 1'b0;
            ob_d_r <= '0;
            ob_last_r <= 1'b0;
            term_pend_r <= 1'b0;
            sp_done_r <= 1'b0;
        end else if (clr) begin
            sh_r <= SH_IDLE;
            dav_r <= 1'b0;
            ob_v_r <= 1'b0;
            term_pend_r <= 1'b0;
        end else begin
            if (!spe_r || !tlk_r) begin
                sp_done_r <= 1'b0;
            end
            if (resp_valid && resp_ready) begin
                ob_v_r <= 1'b1;
                ob_d_r <= resp_data;
                ob_last_r <= resp_last;
            end
            case (sh_r)
                SH_IDLE: begin
                    if (talk_act && spe_r) begin
                        if (!sp_done_r) begin
                            tx_r <= stb_byte;
                            tx_eoi_r <= 1'b0;
                            sp_done_r <= 1'b1;
                            sh_r <= SH_WAIT_RFD;
                        end
                    end else if (talk_act && term_pend_r) begin
                        tx_r <= {1'b0, RESP_TERM};
                        tx_eoi_r <= 1'b1;
                        term_pend_r <= 1'b0;
                        sh_r <= SH_WAIT_RFD;
                    end else if (talk_act && ob_v_r) begin
                        tx_r <= {1'b0, ob_d_r};
                        tx_eoi_r <= 1'b0;
                        ob_v_r <= 1'b0;
                        term_pend_r <= ob_last_r;
                        sh_r <= SH_WAIT_RFD;
                    end
                end
                SH_WAIT_RFD: begin
                    if (!talk_act) begin
                        sh_r <= SH_IDLE;
                    end else if (!nrfd_s && ndac_s) begin
                        dav_r <= 1'b1;
                        sh_r <= SH_VALID;
                    end
                end
                SH_VALID: begin
                    // ATN or untalk mid-byte drops the byte rather than stall the bus
                    if (!talk_act || !ndac_s) begin
                        dav_r <= 1'b0;
                        sh_r <= SH_IDLE;
                    end
                end
                default: sh_r <= SH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            srq_r <= 1'b0;
        end else begin
            srq_r <= srq_req;
        end
    end

    assign dio_o = tx_r;
    assign dio_oe = talk_act && sh_r != SH_IDLE;
    assign dav_o = 1'b1;
    assign dav_oe = dav_r && talk_act;
    assign eoi_o = 1'b1;
    assign eoi_oe = tx_eoi_r && dio_oe;
    assign srq_o = 1'b1;
    assign srq_oe = srq_r;

    a_text_only_listen:
    assert property (@(posedge clk) disable iff (!rst_b)
        (take && (rx_atn_r || !lstn_r)) |=> u_in_buf.cnt_r <= $past(u_in_buf.cnt_r))
        else $error("command text pushed while ATN or not listening");

    a_dcl_flushes:
    assert property (@(posedge clk) disable iff (!rst_b)
        (im_take && rx_r == IM_DCL) |=> dev_clear_o && !ob_v_r && !cmd_valid)
        else $error("device clear did not empty buffers");

    a_sdc_gated:
    assert property (@(posedge clk) disable iff (!rst_b)
        (im_take && rx_r == IM_SDC && !lstn_r) |=> !dev_clear_o)
        else $error("selected clear acted while not listener");

    a_get_trigger:
    assert property (@(posedge clk) disable iff (!rst_b)
        (im_take && rx_r == IM_GET && lstn_r) |=> trig_o ##1 !trig_o)
        else $error("trigger pulse wrong");

    a_nrfd_hold:
    assert property (@(posedge clk) disable iff (!rst_b)
        (!fifo_in_ready && lstn_r && !atn_s && !talk_act) |-> nrfd_oe)
        else $error("NRFD released with full buffer");

    a_listen_addr:
    assert property (@(posedge clk) disable iff (!rst_b)
        (mla_hit && !ifc_s) |=> lstn_r)
        else $error("own listen address not taken");

    a_unlisten:
    assert property (@(posedge clk) disable iff (!rst_b)
        (im_take && rx_r == IM_UNL) |=> !lstn_r)
        else $error("unlisten ignored");

    a_untalk:
    assert property (@(posedge clk) disable iff (!rst_b)
        (im_take && rx_r == IM_UNT) |=> !tlk_r)
        else $error("untalk ignored");

    a_ifc_quiet:
    assert property (@(posedge clk) disable iff (!rst_b) ifc_s |=> !lstn_r && !tlk_r && !spe_r)
        else $error("interface clear left addressing");

    a_eoi_term:
    assert property (@(posedge clk) disable iff (!rst_b) eoi_oe |-> dio_o[6:0] == RESP_TERM)
        else $error("EOI without terminator");

    a_poll_stb:
    assert property (@(posedge clk) disable iff (!rst_b)
        (dav_oe && spe_r && $stable(spe_r)) |-> !tx_eoi_r && tx_r[STB_RQS] == $past(srq_r, 1)
            || !$stable(tx_r))
        else $error("poll byte not status");

endmodule

// File: bench/gdmh_ctrl_model.sv
// Bus controller model: sends bytes with the three-wire handshake and listens
`timescale 1ns/1ps
module gdmh_ctrl_model (
    input wire logic clk,
    input wire logic [7:0] dio_l,
    input wire logic dav_l,
    input wire logic nrfd_l,
    input wire logic ndac_l,
    input wire logic eoi_l,
    output logic [7:0] c_dio,
    output logic c_dav,
    output logic c_nrfd,
    output logic c_ndac,
    output logic c_eoi,
    output logic c_atn
);
    int n;
    // Handshake waits that ran out; the bench counts them as mismatches
    int n_stall = 0;
    initial begin
        {c_dio, c_dav, c_nrfd, c_ndac, c_eoi, c_atn} = '0;
    end
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // Messages go with ATN true, text with ATN false
    task automatic send(input logic atn, input logic [7:0] b, input logic e);
        {c_nrfd, c_ndac, c_atn} = {1'b0, 1'b0, atn};
        // A talking device only joins the handshake once it has seen ATN
        repeat (3) step();
        for (n = 0; n < 300 && nrfd_l; n++) step();
        if (n == 300) n_stall++;
        {c_dio, c_eoi} = {b, e};
        step();
        c_dav = 1'b1;
        // DAV stays up until every acceptor lets NDAC go
        for (n = 0; n < 300 && ndac_l; n++) step();
        if (n == 300) n_stall++;
        {c_dav, c_dio, c_eoi} = '0;
        step();
    endtask
    task automatic recv(output logic [7:0] b, output logic e);
        {c_atn, c_ndac, c_nrfd} = 3'b010;
        for (n = 0; n < 300 && !dav_l; n++) step();
        if (n == 300) n_stall++;
        {b, e} = {dio_l, eoi_l};
        {c_nrfd, c_ndac} = 2'b10;
        for (n = 0; n < 300 && dav_l; n++) step();
        if (n == 300) n_stall++;
        c_ndac = 1'b1;
        step();
    endtask
endmodule

// File: bench/gdmh_bench.sv
// Self-checking bench: controller model on the bus, bench on the user streams
`timescale 1ns/1ps
module gdmh_bench
    import gdmh_pkg::*;
;
    localparam logic [4:0] MY = 5'h05;
    logic clk, rst_b, ren, ifc, cmd_ready, resp_valid, resp_ready, resp_last, srq_req, rx_e;
    logic [6:0] resp_data, cmd_data;
    logic [7:0] dio_o, c_dio, dio_l, rx;
    logic dio_oe, dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, c_dav, c_nrfd, c_ndac, c_eoi, c_atn;
    logic cmd_valid, cmd_end, cmd_msg_end, cmd_common, cmd_query, trig_o, dev_clear_o;
    logic remote_o, lockout_o, listen_o, talk_o, spoll_o, dav_l, nrfd_l, ndac_l, eoi_l;
    logic [10:0] words[$];
    int err_total, n_tests, n_clr, n_trig, n;
    // Wired-OR in asserted sense; a released line reads false
    assign dio_l = (dio_oe ? dio_o : 8'h00) | c_dio;
    assign dav_l = dav_oe | c_dav;
    assign nrfd_l = nrfd_oe | c_nrfd;
    assign ndac_l = ndac_oe | c_ndac;
    assign eoi_l = eoi_oe | c_eoi;
    gdmh_top i_gdmh_top (.clk(clk), .rst_b(rst_b), .my_addr(MY), .dio_i(dio_l), .dio_o(dio_o),
        .dio_oe(dio_oe), .dav_i(dav_l), .dav_o(), .dav_oe(dav_oe), .nrfd_i(nrfd_l), .nrfd_o(),
        .nrfd_oe(nrfd_oe), .ndac_i(ndac_l), .ndac_o(), .ndac_oe(ndac_oe), .eoi_i(eoi_l),
        .eoi_o(), .eoi_oe(eoi_oe), .srq_o(), .srq_oe(srq_oe), .atn_i(c_atn), .ifc_i(ifc),
        .ren_i(ren), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
        .cmd_end(cmd_end), .cmd_msg_end(cmd_msg_end), .cmd_common(cmd_common),
        .cmd_query(cmd_query), .resp_valid(resp_valid), .resp_ready(resp_ready),
        .resp_data(resp_data), .resp_last(resp_last), .status_in(8'h05), .srq_req(srq_req),
        .trig_o(trig_o), .dev_clear_o(dev_clear_o), .remote_o(remote_o), .lockout_o(lockout_o),
        .listen_o(listen_o), .talk_o(talk_o), .spoll_o(spoll_o));
    gdmh_ctrl_model i_ctrl (.clk(clk), .dio_l(dio_l), .dav_l(dav_l), .nrfd_l(nrfd_l),
        .ndac_l(ndac_l), .eoi_l(eoi_l), .c_dio(c_dio), .c_dav(c_dav), .c_nrfd(c_nrfd),
        .c_ndac(c_ndac), .c_eoi(c_eoi), .c_atn(c_atn));
    always @(posedge clk) begin
        if (cmd_valid && cmd_ready) begin
            words.push_back({cmd_query, cmd_common, cmd_msg_end, cmd_end, cmd_data});
        end
        if (dev_clear_o) n_clr++;
        if (trig_o) n_trig++;
    end
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string s, input logic [10:0] g, input logic [10:0] e);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", s, e, g);
            err_total++;
        end
    endtask
    task automatic msg(input logic [6:0] m);
        i_ctrl.send(1'b1, {1'b0, m}, 1'b0);
        wt(4);
    endtask
    task automatic feed(input logic [6:0] d);
        {resp_valid, resp_data, resp_last} = {1'b1, d, 1'b1};
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (resp_ready === 1'b1) break;
        end
        #1;
        resp_valid = 1'b0;
        chk("resp_ready", 11'(n < 200), 11'h1);
    endtask
    task automatic t_text();
        logic [7:0] tb[8] = '{8'h2A, 8'hC1, 8'h07, 8'h3F, 8'h3B, 8'h42, 8'h43, 8'h0D};
        logic [10:0] ew[7] = '{11'h02A, 11'h041, 11'h03F, 11'h6BB, 11'h1C2, 11'h043, 11'h18D};
        msg({GRP_LISTEN, MY});
        chk("listen", listen_o, 1'b1);
        chk("remote", remote_o, 1'b1);
        words.delete();
        for (int i = 0; i < 8; i++) i_ctrl.send(1'b0, tb[i], i == 5);
        wt(8);
        chk("words", 11'(words.size()), 11'h7);
        for (int i = 0; i < 7; i++) begin
            chk("word", words[i] & (ew[i][7] ? 11'h7FF : 11'h1FF), ew[i]);
        end
    endtask
    task automatic t_trig_clear();
        n_trig = 0;
        msg(IM_GET);
        chk("trig", 11'(n_trig), 11'h1);
        cmd_ready = 1'b0;
        i_ctrl.send(1'b0, 8'h78, 1'b0);
        wt(6);
        chk("valid", cmd_valid, 1'b1);
        n_clr = 0;
        msg(IM_DCL);
        chk("valid", cmd_valid, 1'b0);
        chk("clear", 11'(n_clr), 11'h1);
        msg(IM_UNL);
        msg(IM_SDC);
        chk("clear", 11'(n_clr), 11'h1);
        msg({GRP_LISTEN, MY});
        msg(IM_SDC);
        chk("clear", 11'(n_clr), 11'h2);
    endtask
    task automatic t_fill();
        words.delete();
        for (int i = 0; i < 17; i++) i_ctrl.send(1'b0, 8'(8'h61 + i), 1'b0);
        fork
            i_ctrl.send(1'b0, 8'h7A, 1'b0);
            begin
                wt(40);
                chk("hold", nrfd_oe, 1'b1);
                cmd_ready = 1'b1;
            end
        join
        wt(30);
        chk("drain", 11'(words.size()), 11'd18);
        chk("last", words[17][6:0], 7'h7A);
        msg(IM_UNL);
        chk("listen", listen_o, 1'b0);
        i_ctrl.send(1'b0, 8'h58, 1'b0);
        wt(8);
        chk("drop", 11'(words.size()), 11'd18);
    endtask
    task automatic t_remote();
        msg({GRP_LISTEN, MY});
        msg(IM_LLO);
        chk("lockout", lockout_o, 1'b1);
        msg(IM_GTL);
        chk("remote", remote_o, 1'b0);
        ren = 1'b0;
        wt(6);
        chk("lockout", lockout_o, 1'b0);
        ren = 1'b1;
    endtask
    task automatic t_talk_poll();
        feed(7'h35);
        msg({GRP_TALK, MY});
        chk("talk", talk_o, 1'b1);
        i_ctrl.recv(rx, rx_e);
        chk("text", {rx_e, rx}, 9'h035);
        i_ctrl.recv(rx, rx_e);
        chk("term", {rx_e, rx}, {2'b10, RESP_TERM});
        msg(IM_UNT);
        chk("talk", talk_o, 1'b0);
        srq_req = 1'b1;
        wt(3);
        chk("srq", srq_oe, 1'b1);
        msg(IM_SPE);
        msg({GRP_TALK, MY});
        chk("spoll", spoll_o, 1'b1);
        i_ctrl.recv(rx, rx_e);
        chk("stb", rx, 8'h45);
        msg(IM_UNT);
        msg(IM_SPD);
        chk("spoll", spoll_o, 1'b0);
        feed(7'h37);
        msg({GRP_TALK, MY});
        i_ctrl.recv(rx, rx_e);
        chk("data", rx, 8'h37);
        i_ctrl.recv(rx, rx_e);
        msg({GRP_LISTEN, MY});
        ifc = 1'b1;
        wt(4);
        ifc = 1'b0;
        wt(4);
        chk("ifc", {listen_o, talk_o}, 2'b00);
    endtask
    task automatic conclude();
        chk("stalls", 11'(i_ctrl.n_stall), 11'h0);
        if (err_total == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Whole sequence needs under a thousand cycles; thirty times that is a hang
    initial begin
        wt(30000);
        err_total++;
        conclude();
    end
    initial begin
        {rst_b, ren, ifc, cmd_ready, resp_valid, resp_last, srq_req} = 7'b0101000;
        resp_data = 7'h00;
        repeat (10) @(posedge clk);
        #1;
        rst_b = 1'b1;
        wt(4);
        t_text();
        t_trig_clear();
        t_fill();
        t_remote();
        t_talk_poll();
        conclude();
    end
endmodule
